// ==== rtl/flex_io_pin_configuration.sv ====
// flex io pin configuration core with classic wishbone register slave
// assumes pads outside resolve pin level from oe/out and apply pull enables;
// step_clock/step_direction feed the clock-direction motion logic elsewhere
`timescale 1ns/1ns
`default_nettype none

module flex_io_pin_configuration
    import flex_io_pkg::*;
#(
    parameter int NUM_PINS = PIN_COUNT
)
(
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADR_W-1:0]    wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [DATA_W-1:0]   wb_dat_i,
    output logic      [DATA_W-1:0]   wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic [NUM_PINS-1:0] multipurpose_pin_in,
    output logic      [NUM_PINS-1:0] multipurpose_pin_out,
    output logic      [NUM_PINS-1:0] multipurpose_pin_oe,
    output logic      [NUM_PINS-1:0] multipurpose_pin_pull_up_en,
    output logic      [NUM_PINS-1:0] multipurpose_pin_pull_down_en,
    output logic                     step_clock,
    output logic                     step_direction
);

    // the state struct and pin mapping are sized for the package pin count
    if (NUM_PINS != PIN_COUNT)
    begin : g_bad_pins
        $error("NUM_PINS must equal the package pin count");
    end

    // pins that own an alternate function
    function automatic logic alt_capable(input int idx);
        return (idx == STEP_CLOCK_PIN) || (idx == STEP_DIRECTION_PIN);
    endfunction

    // byte-lane merge of a pin mask; upper mask bits are never stored
    function automatic logic [PIN_COUNT-1:0] lane_merge(input logic [PIN_COUNT-1:0] old_v,
                                                       input logic [DATA_W-1:0]    new_v,
                                                       input logic [3:0]           sel);
        return sel[0] ? new_v[PIN_COUNT-1:0] : old_v;
    endfunction

    core_state_t          state_q;
    core_state_t          state_d;
    logic [PIN_COUNT-1:0] alt_eff;
    logic [PIN_COUNT-1:0] dir_eff;
    logic [PIN_COUNT-1:0] pin_sync;
    logic                 bus_req;
    logic                 bus_wr;

    assign bus_req = wb_cyc_i & wb_stb_i & ~state_q.ack;
    assign bus_wr  = bus_req & wb_we_i;

    // effective per-pin settings; alternate functions are inputs
    // alternate overrides direction
    for (genvar i = 0; i < PIN_COUNT; i++)
    begin : g_pin
        pin_cfg_t cfg;

        assign alt_eff[i]  = alt_capable(i) & state_q.alt[i];
        assign dir_eff[i]  = state_q.dir[i] & ~alt_eff[i];
        assign cfg.drive   = dir_eff[i];
        assign cfg.pull_up = state_q.bias[i];
        assign cfg.level   = state_q.level[i];

        flex_io_pin_cell flex_io_pin_cell_inst (
            .ref_clk      (ref_clk),
            .rst          (rst),
            .cfg          (cfg),
            .pin_in       (multipurpose_pin_in[i]),
            .pin_out      (multipurpose_pin_out[i]),
            .pin_oe       (multipurpose_pin_oe[i]),
            .pull_up_en   (multipurpose_pin_pull_up_en[i]),
            .pull_down_en (multipurpose_pin_pull_down_en[i]),
            .pin_sync     (pin_sync[i])
        );
    end

    // register writes, mode override, read mux and step outputs
    always_comb
    begin
        state_d     = state_q;
        state_d.ack = bus_req;
        if (bus_wr)
        begin
            // only the pin bits are kept
            case (wb_adr_i)
                OFS_DIRECTION: state_d.dir   = lane_merge(state_q.dir, wb_dat_i, wb_sel_i);
                OFS_BIAS:      state_d.bias  = lane_merge(state_q.bias, wb_dat_i, wb_sel_i);
                OFS_ALT_FUNC:  state_d.alt   = lane_merge(state_q.alt, wb_dat_i, wb_sel_i);
                OFS_LEVEL:     state_d.level = lane_merge(state_q.level, wb_dat_i, wb_sel_i);
                OFS_CONTROL:
                begin
                    if (wb_sel_i[0])
                    begin
                        state_d.cd_mode = wb_dat_i[CTRL_CD_MODE_BIT];
                    end
                end
                default: ;
            endcase
        end
        // hardware wins over software writes to the alt and dir bits of pins 1 and 2 while the mode is on
        if (state_d.cd_mode)
        begin
            state_d.alt[STEP_CLOCK_PIN]     = 1'b1;
            state_d.alt[STEP_DIRECTION_PIN] = 1'b1;
            state_d.dir[STEP_CLOCK_PIN]     = 1'b0;
            state_d.dir[STEP_DIRECTION_PIN] = 1'b0;
        end
        // read data is registered with the ack; unmapped words read zero
        state_d.rdata = '0;
        if (bus_req && !wb_we_i)
        begin
            // upper mask bits read as zero
            case (wb_adr_i)
                OFS_DIRECTION: state_d.rdata[PIN_COUNT-1:0] = state_q.dir;
                OFS_BIAS:      state_d.rdata[PIN_COUNT-1:0] = state_q.bias;
                OFS_ALT_FUNC:  state_d.rdata[PIN_COUNT-1:0] = state_q.alt;
                OFS_LEVEL:     state_d.rdata[PIN_COUNT-1:0] = state_q.level;
                OFS_CONTROL:   state_d.rdata[CTRL_CD_MODE_BIT] = state_q.cd_mode;
                OFS_STATUS:
                begin
                    state_d.rdata[STAT_INPUT_LSB +: PIN_COUNT] = pin_sync;
                    state_d.rdata[STAT_OE_LSB +: PIN_COUNT]    = dir_eff;
                    state_d.rdata[STAT_CD_MODE_BIT]            = state_q.cd_mode;
                end
                default: ;
            endcase
        end
        // pin 1 clock, pin 2 direction, low when not routed
        state_d.step_clock     = alt_eff[STEP_CLOCK_PIN] & pin_sync[STEP_CLOCK_PIN];
        state_d.step_direction = alt_eff[STEP_DIRECTION_PIN] & pin_sync[STEP_DIRECTION_PIN];
    end

    // single state register; everything resets to the documented defaults
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '{dir: DIRECTION_RESET, bias: BIAS_RESET, alt: ALT_FUNC_RESET,
                         level: LEVEL_RESET, cd_mode: 1'b0, ack: 1'b0, rdata: '0,
                         step_clock: 1'b0, step_direction: 1'b0};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign wb_dat_o       = state_q.rdata;
    assign wb_ack_o       = state_q.ack;
    assign step_clock     = state_q.step_clock;
    assign step_direction = state_q.step_direction;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_mask_write(logic [ADR_W-1:0] ofs);
        wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == ofs;
    endsequence

    // bus answer is a single-cycle pulse
    chk_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    // never both pulls on one pin
    chk_pulls_exclusive: assert property (!(|(multipurpose_pin_pull_up_en & multipurpose_pin_pull_down_en)))
        else $error("pull-up and pull-down enabled together");

    // written bits land on matching pins
    chk_dir_bit_mapping: assert property (s_mask_write(OFS_DIRECTION) ##0 !state_d.cd_mode
                                          |=> state_q.dir == $past(wb_dat_i[PIN_COUNT-1:0]))
        else $error("direction mask write not stored bit for bit");

    // direction mask reaches the output enables
    chk_dir_drives_oe: assert property (1'b1 |=> multipurpose_pin_oe == $past(dir_eff))
        else $error("output enable does not follow effective direction");

    // alternate function keeps the pin an input
    chk_alt_forces_input: assert property (alt_eff[STEP_CLOCK_PIN] ##1 alt_eff[STEP_CLOCK_PIN]
                                           |-> !multipurpose_pin_oe[STEP_CLOCK_PIN])
        else $error("alternate function pin driven as output");

    // bias mask selects pull-up on an input
    chk_bias_pull_up: assert property (!dir_eff[0] && state_q.bias[0]
                                       |=> multipurpose_pin_pull_up_en[0] && !multipurpose_pin_pull_down_en[0])
        else $error("input pin with bias bit set lacks pull-up");

    chk_bias_on_output: assert property (dir_eff[3]
                                         |=> !multipurpose_pin_pull_up_en[3] && !multipurpose_pin_pull_down_en[3])
        else $error("bias applied to an output pin");

    // step clock follows pin 1 only when routed
    chk_step_clock_route: assert property (!alt_eff[STEP_CLOCK_PIN] |=> !step_clock)
        else $error("step clock active without alternate function");

    // mode forces clock and direction pins
    chk_cd_override: assert property (state_q.cd_mode |-> state_q.alt[2:1] == 2'b11 && state_q.dir[2:1] == 2'b00)
        else $error("clock-direction mode did not override masks");

    chk_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[DATA_W-1:STAT_CD_MODE_BIT+1] == '0)
        else $error("unused register bits read non-zero");

endmodule
`default_nettype wire

// ==== shared/flex_io_pkg.sv ====
// flex io pin configuration: register map, field layout, reset values, types
// assumes a 32-bit classic wishbone register bus and four multipurpose pins
package flex_io_pkg;

    localparam int PIN_COUNT = 4;
    localparam int ADR_W     = 8;
    localparam int DATA_W    = 32;
    localparam int MASK_W    = 16;

    // byte addresses of the register words
    localparam logic [ADR_W-1:0] OFS_DIRECTION = 8'h00;
    localparam logic [ADR_W-1:0] OFS_BIAS      = 8'h04;
    localparam logic [ADR_W-1:0] OFS_ALT_FUNC  = 8'h08;
    localparam logic [ADR_W-1:0] OFS_CONTROL   = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_LEVEL     = 8'h10;
    localparam logic [ADR_W-1:0] OFS_STATUS    = 8'h14;

    // reset values
    localparam logic [PIN_COUNT-1:0] DIRECTION_RESET = 4'h0;
    localparam logic [PIN_COUNT-1:0] BIAS_RESET      = 4'h0;
    localparam logic [PIN_COUNT-1:0] ALT_FUNC_RESET  = 4'h0;
    localparam logic [PIN_COUNT-1:0] LEVEL_RESET     = 4'h0;

    // field positions
    localparam int CTRL_CD_MODE_BIT   = 0;
    localparam int STAT_INPUT_LSB     = 0;
    localparam int STAT_OE_LSB        = 4;
    localparam int STAT_CD_MODE_BIT   = 8;
    localparam int STEP_CLOCK_PIN     = 1;
    localparam int STEP_DIRECTION_PIN = 2;

    // effective configuration handed to one pin cell
    typedef struct packed {
        logic drive;
        logic pull_up;
        logic level;
    } pin_cfg_t;

    // all state of one pin cell
    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic oe;
        logic out;
        logic pu;
        logic pd;
    } pin_cell_state_t;

    // all state of the configuration core
    typedef struct packed {
        logic [PIN_COUNT-1:0] dir;
        logic [PIN_COUNT-1:0] bias;
        logic [PIN_COUNT-1:0] alt;
        logic [PIN_COUNT-1:0] level;
        logic                 cd_mode;
        logic                 ack;
        logic [DATA_W-1:0]    rdata;
        logic                 step_clock;
        logic                 step_direction;
    } core_state_t;

endpackage

// ==== rtl/flex_io_pin_cell.sv ====
// one multipurpose pin: registered drive, bias selects and input synchroniser
// assumes the pad works out the wire level from oe and out, and applies the pulls
`timescale 1ns/1ns
`default_nettype none
module flex_io_pin_cell
    import flex_io_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     rst,
    input  wire pin_cfg_t cfg,
    input  wire logic     pin_in,
    output logic          pin_out,
    output logic          pin_oe,
    output logic          pull_up_en,
    output logic          pull_down_en,
    output logic          pin_sync
);

    pin_cell_state_t state_q;
    pin_cell_state_t state_d;

    // next state: two-stage sync, drive and bias from the effective config
    always_comb
    begin
        state_d        = state_q;
        state_d.sync_a = pin_in;
        state_d.sync_b = state_q.sync_a;
        state_d.oe     = cfg.drive;
        state_d.out    = cfg.drive & cfg.level;
        state_d.pu     = ~cfg.drive & cfg.pull_up;
        state_d.pd     = ~cfg.drive & ~cfg.pull_up;
    end

    // pins come up as inputs with pull-down, matching the mask defaults
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= '{sync_a: 1'b0, sync_b: 1'b0, oe: 1'b0, out: 1'b0, pu: 1'b0, pd: 1'b1};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign pin_out      = state_q.out;
    assign pin_oe       = state_q.oe;
    assign pull_up_en   = state_q.pu;
    assign pull_down_en = state_q.pd;
    assign pin_sync     = state_q.sync_b;

endmodule
`default_nettype wire

// ==== tb/flex_io_pad_model.sv ====
// pad model: external circuitry and pull resistors on the four pins
// assumes the bench steers one external driver per pin
`timescale 1ns/1ns
`default_nettype none
module flex_io_pad_model
    import flex_io_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic [PIN_COUNT-1:0] oe,
    input  wire logic [PIN_COUNT-1:0] out,
    input  wire logic [PIN_COUNT-1:0] pu,
    input  wire logic [PIN_COUNT-1:0] pd,
    input  wire logic [PIN_COUNT-1:0] ext_en,
    input  wire logic [PIN_COUNT-1:0] ext_lvl,
    output logic      [PIN_COUNT-1:0] level
);
    logic [PIN_COUNT-1:0] float_q = 4'h5;

    // an unpulled, undriven wire wanders, so a stale value never passes
    always_ff @(posedge ref_clk)
    begin
        float_q <= ~float_q;
    end

    // pulls matter only where nobody drives
    always_comb
    begin
        level = (oe & out) | (~oe & ext_en & ext_lvl) | (~oe & ~ext_en & (pu | (~pd & float_q)));
    end
endmodule
`default_nettype wire

// ==== tb/flex_io_pin_configuration_bench.sv ====
// bench for the pin configuration block: wishbone master, pad model, scoreboard
// assumes exactly one ack cycle per request and four pins
`timescale 1ns/1ns
`default_nettype none
module flex_io_pin_configuration_bench;
    import flex_io_pkg::*;
    logic                 ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, step_clock, step_direction, wb_ack_o;
    logic [ADR_W-1:0]     wb_adr_i;
    logic [3:0]           wb_sel_i, pin_in, pin_out, pin_oe, pin_pu, pin_pd, ext_en, ext_lvl, lv;
    logic [DATA_W-1:0]    wb_dat_i, wb_dat_o, d, b;
    logic [DATA_W-1:0]    exp_q[$];
    int                   err_count, samples_checked, seed;

    flex_io_pin_configuration flex_io_pin_configuration_inst (.ref_clk(ref_clk), .rst(rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .multipurpose_pin_in(pin_in), .multipurpose_pin_out(pin_out), .multipurpose_pin_oe(pin_oe),
        .multipurpose_pin_pull_up_en(pin_pu), .multipurpose_pin_pull_down_en(pin_pd),
        .step_clock(step_clock), .step_direction(step_direction));
    flex_io_pad_model flex_io_pad_model_inst (.ref_clk(ref_clk), .oe(pin_oe), .out(pin_out),
        .pu(pin_pu), .pd(pin_pd), .ext_en(ext_en), .ext_lvl(ext_lvl), .level(pin_in));

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; reads leave their expected word in the queue
    task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] dt,
                      input logic [3:0] s, input logic [DATA_W-1:0] e);
        if (!w)
            exp_q.push_back(e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= dt;
        wb_sel_i <= s;
        @(posedge ref_clk);
        // no answer time assumed: only the watchdog ends a stuck wait
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge ref_clk);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge ref_clk);
    endtask

    // effective pin setup from direction, bias and alternate masks
    task automatic pins(input logic [3:0] dm, input logic [3:0] bm, input logic [3:0] am);
        logic [3:0] inp;
        inp = ~dm | (am & 4'h6);
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_oe, 4'(~inp));
        check(pin_pu, inp & bm);
        check(pin_pd, inp & ~bm);
        check(pin_out, 4'h0);
        @(posedge ref_clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // scoreboard: every read ack consumes the oldest note
    always @(posedge ref_clk)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            check(wb_dat_o, exp_q.size() > 0 ? exp_q.pop_front() : 32'hDEAD_BEEF);
    end

    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // far longer than the few hundred cycles the tests need
    initial
    begin
        #100000;
        err_count++;
        give_verdict();
    end

    initial
    begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_sel_i, wb_dat_i, ext_en, ext_lvl} = '0;
        err_count = 0;
        samples_checked = 0;
        seed = $urandom(67527);
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        // masks start cleared: inputs with pull-down
        for (int r = 0; r < 3; r++)
            wb(1'b0, OFS_DIRECTION + 8'(4 * r), 0, 4'hF, 32'h0);
        pins(4'h0, 4'h0, 4'h0);
        $display("test reset done");
        repeat (6)
        begin
            d = $urandom;
            b = $urandom;
            wb(1'b1, OFS_DIRECTION, d, 4'hF, 0);
            wb(1'b1, OFS_BIAS, b, 4'hF, 0);
            wb(1'b0, OFS_DIRECTION, 0, 4'hF, d & 32'hF);
            wb(1'b0, OFS_BIAS, 0, 4'hF, b & 32'hF);
            pins(d[3:0], b[3:0], 4'h0);
        end
        wb(1'b1, OFS_DIRECTION, ~d, 4'h0, 0);
        wb(1'b0, OFS_DIRECTION, 0, 4'hF, d & 32'hF);
        $display("test masks done");
        // alternate pins turn into inputs feeding the step logic
        wb(1'b1, OFS_DIRECTION, 32'hF, 4'hF, 0);
        wb(1'b1, OFS_ALT_FUNC, 32'hF, 4'hF, 0);
        pins(4'hF, b[3:0], 4'hF);
        repeat (4)
        begin
            lv = 4'($urandom);
            ext_en <= 4'h6;
            ext_lvl <= lv;
            repeat (4) @(posedge ref_clk);
            #1;
            check(step_clock, lv[1]);
            check(step_direction, lv[2]);
            @(posedge ref_clk);
        end
        ext_en <= 4'h0;
        $display("test alternate done");
        wb(1'b1, OFS_ALT_FUNC, 32'h0, 4'hF, 0);
        wb(1'b1, OFS_CONTROL, 32'h1, 4'hF, 0);
        wb(1'b0, OFS_DIRECTION, 0, 4'hF, 32'h9);
        wb(1'b0, OFS_ALT_FUNC, 0, 4'hF, 32'h6);
        pins(4'h9, b[3:0], 4'h6);
        // output level drives only the output pins; status shows pads, oe and mode
        wb(1'b1, OFS_LEVEL, 32'hF, 4'hF, 0);
        wb(1'b0, OFS_LEVEL, 0, 4'hF, 32'hF);
        repeat (2) @(posedge ref_clk);
        #1;
        check(pin_out, 4'h9);
        check(step_clock, b[1]);
        check(step_direction, b[2]);
        @(posedge ref_clk);
        wb(1'b0, OFS_STATUS, 0, 4'hF, {23'h0, 1'b1, 4'h9, 4'h9 | (b[3:0] & 4'h6)});
        $display("test cd mode done");
        wb(1'b1, 8'h40, 32'hFFFF_FFFF, 4'hF, 0);
        wb(1'b0, 8'h40, 0, 4'hF, 32'h0);
        check(exp_q.size(), 0);
        $display("test unmapped done");
        give_verdict();
    end
endmodule
`default_nettype wire
